// File: design/adc_cfg_pkg.sv
// constants shared by the converter configuration register bank
package adc_cfg_pkg;

  // ----------------------------------------------------------------
  // widths and serial frame
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int SAMPLE_W = 14;
  localparam logic [4:0] ADDR_BITS = 5'h08;
  localparam logic [4:0] FRAME_BITS = 5'h10;

  // ----------------------------------------------------------------
  // register addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_SWING = 8'h01;
  localparam logic [7:0] ADDR_TUNE0 = 8'h03;
  localparam logic [7:0] ADDR_TUNE1 = 8'h06;
  localparam logic [7:0] ADDR_GAIN_A = 8'h25;
  localparam logic [7:0] ADDR_FORMAT = 8'h29;
  localparam logic [7:0] ADDR_GAIN_B = 8'h2B;
  localparam logic [7:0] ADDR_OFFS = 8'h3D;
  localparam logic [7:0] ADDR_CUST_HI = 8'h3F;
  localparam logic [7:0] ADDR_CUST_LO = 8'h40;
  localparam logic [7:0] ADDR_IFACE = 8'h41;
  localparam logic [7:0] ADDR_CLKDLY = 8'h42;
  localparam logic [7:0] ADDR_DIGEN = 8'h44;

  // ----------------------------------------------------------------
  // writable bit masks, reserved bits stay zero
  // ----------------------------------------------------------------
  localparam logic [7:0] MASK_SWING = 8'hFC;
  localparam logic [7:0] MASK_TUNE0 = 8'h02;
  localparam logic [7:0] MASK_TUNE1 = 8'h06;
  localparam logic [7:0] MASK_GAIN = 8'hF7;
  localparam logic [7:0] MASK_FORMAT = 8'h18;
  localparam logic [7:0] MASK_OFFS = 8'h20;
  localparam logic [7:0] MASK_CUST_HI = 8'h3F;
  localparam logic [7:0] MASK_CUST_LO = 8'hFF;
  localparam logic [7:0] MASK_IFACE = 8'hF3;
  localparam logic [7:0] MASK_CLKDLY = 8'hF0;
  localparam logic [7:0] MASK_DIGEN = 8'h01;
  localparam logic [7:0] REG_RESET = 8'h00;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CTRL_READOUT_BIT = 0;
  localparam int CTRL_RESET_BIT = 1;
  localparam int SWING_LSB = 2;
  localparam int TUNE0_BIT = 1;
  localparam int TUNE1_LSB = 1;
  localparam int GAIN_LSB = 4;
  localparam int PAT_LSB = 0;
  localparam int FORMAT_LSB = 3;
  localparam int OFFS_BIT = 5;
  localparam int IFACE_LSB = 6;
  localparam int DRIVE_LSB = 4;
  localparam int BUFPD_LSB = 0;
  localparam int CLKDLY_LSB = 4;
  localparam int DIGEN_BIT = 0;

  // ----------------------------------------------------------------
  // field codes
  // ----------------------------------------------------------------
  localparam logic [2:0] PAT_NORMAL = 3'h0;
  localparam logic [2:0] PAT_ZEROS = 3'h1;
  localparam logic [2:0] PAT_ONES = 3'h2;
  localparam logic [2:0] PAT_TOGGLE = 3'h3;
  localparam logic [2:0] PAT_RAMP = 3'h4;
  localparam logic [2:0] PAT_CUSTOM = 3'h5;
  localparam logic [1:0] FORMAT_OFFSET_BIN = 2'h3;
  localparam logic [1:0] IFACE_CMOS = 2'h3;
  localparam logic [1:0] BUFPD_BOTH = 2'h3;
  localparam logic [13:0] TOGGLE_WORD = 14'h2AAA;
  localparam logic [13:0] RAMP_STEP = 14'h0001;

  // serial frame phase
  typedef enum logic [1:0] {PH_IDLE, PH_ADDR, PH_DATA, PH_DONE} frame_phase_t;

endpackage

// File: design/serial_cfg_port.sv
// serial configuration port: frame capture and readback shifter
`timescale 1ns/1ps
module serial_cfg_port
  import adc_cfg_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rstSync_b,
  input wire logic serialEnable_b,
  input wire logic serialClock,
  input wire logic serialDataIn,
  input wire logic [7:0] readData,
  output logic [7:0] cycleAddr,
  output logic [7:0] cycleData,
  output logic writeStrobe,
  output logic serialDataOutPin
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  frame_phase_t phase_r, phase_nxt;
  logic sclkPrev_r, sclkPrev_nxt;
  logic [4:0] bitCnt_r, bitCnt_nxt;
  logic [7:0] shift_r, shift_nxt;
  logic [7:0] addr_r, addr_nxt;
  logic [7:0] data_r, data_nxt;
  logic addrDone_r, addrDone_nxt;
  logic strobe_r, strobe_nxt;
  logic [7:0] outShift_r, outShift_nxt;
  logic rise;

  assign rise = serialClock & ~sclkPrev_r;

  // next state: bits taken on the rising serial clock, msb first
  always_comb begin
    phase_nxt = phase_r;
    sclkPrev_nxt = serialClock;
    bitCnt_nxt = bitCnt_r;
    shift_nxt = shift_r;
    addr_nxt = addr_r;
    data_nxt = data_r;
    addrDone_nxt = 1'b0;
    strobe_nxt = 1'b0;
    outShift_nxt = outShift_r;
    if (serialEnable_b) begin
      phase_nxt = PH_IDLE;
      bitCnt_nxt = 5'h00;
    end else if (phase_r == PH_IDLE) begin
      phase_nxt = PH_ADDR;
      bitCnt_nxt = 5'h00;
      if (rise) begin
        shift_nxt = {shift_r[6:0], serialDataIn};
        bitCnt_nxt = 5'h01;
      end
    end else if (rise && phase_r != PH_DONE) begin
      shift_nxt = {shift_r[6:0], serialDataIn};
      bitCnt_nxt = bitCnt_r + 5'h01;
      if (bitCnt_r == ADDR_BITS - 5'h01) begin
        addr_nxt = {shift_r[6:0], serialDataIn};
        addrDone_nxt = 1'b1;
        phase_nxt = PH_DATA;
      end else if (bitCnt_r == FRAME_BITS - 5'h01) begin
        data_nxt = {shift_r[6:0], serialDataIn};
        strobe_nxt = 1'b1;
        phase_nxt = PH_DONE;
      end
    end
    // readback word loads once the address is known, then moves on each rise
    if (addrDone_r) begin
      outShift_nxt = readData;
    end else if (rise && phase_r == PH_DATA && !serialEnable_b) begin
      outShift_nxt = {outShift_r[6:0], 1'b0};
    end
  end

  // registers
  always_ff @(posedge ref_clk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      phase_r <= PH_IDLE;
      sclkPrev_r <= 1'b0;
      bitCnt_r <= 5'h00;
      shift_r <= 8'h00;
      addr_r <= 8'h00;
      data_r <= 8'h00;
      addrDone_r <= 1'b0;
      strobe_r <= 1'b0;
      outShift_r <= 8'h00;
    end else begin
      phase_r <= phase_nxt;
      sclkPrev_r <= sclkPrev_nxt;
      bitCnt_r <= bitCnt_nxt;
      shift_r <= shift_nxt;
      addr_r <= addr_nxt;
      data_r <= data_nxt;
      addrDone_r <= addrDone_nxt;
      strobe_r <= strobe_nxt;
      outShift_r <= outShift_nxt;
    end
  end

  assign cycleAddr = addr_r;
  assign cycleData = data_r;
  assign writeStrobe = strobe_r;
  assign serialDataOutPin = outShift_r[7];

endmodule

// File: design/test_pattern_gen.sv
// one channel of output data selection: converted data or test pattern
`timescale 1ns/1ps
module test_pattern_gen
  import adc_cfg_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rstSync_b,
  input wire logic [2:0] patternSel,
  input wire logic [13:0] customPattern,
  input wire logic digitalEn,
  input wire logic offsetBinary,
  input wire logic [13:0] sampleIn,
  output logic [13:0] sampleOut
);

  logic toggle_r, toggle_nxt;
  logic [13:0] ramp_r, ramp_nxt;
  logic [13:0] out_r, out_nxt;
  logic [13:0] converted;

  // converter data arrives offset binary; flip msb for twos complement
  assign converted = offsetBinary ? sampleIn : {~sampleIn[13], sampleIn[12:0]};

  // pattern select, only while digital functions are enabled
  always_comb begin
    toggle_nxt = ~toggle_r;
    ramp_nxt = ramp_r + RAMP_STEP;
    out_nxt = converted;
    if (digitalEn) begin
      case (patternSel)
        PAT_ZEROS: out_nxt = 14'h0000;
        PAT_ONES: out_nxt = 14'h3FFF;
        PAT_TOGGLE: out_nxt = toggle_r ? ~TOGGLE_WORD : TOGGLE_WORD;
        PAT_RAMP: out_nxt = ramp_r;
        PAT_CUSTOM: out_nxt = customPattern;
        default: out_nxt = converted;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      toggle_r <= 1'b0;
      ramp_r <= 14'h0000;
      out_r <= 14'h0000;
    end else begin
      toggle_r <= toggle_nxt;
      ramp_r <= ramp_nxt;
      out_r <= out_nxt;
    end
  end

  assign sampleOut = out_r;

endmodule

// File: design/adc_serial_config_registers.sv
// configuration register bank of a dual-channel converter, serial access
`timescale 1ns/1ps
module adc_serial_config_registers
  import adc_cfg_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic serialEnable_b,
  input wire logic serialClock,
  input wire logic serialDataIn,
  output logic serialDataOutPin,
  output logic serialDataOutEn,
  input wire logic [13:0] chanASample,
  input wire logic [13:0] chanBSample,
  output logic [13:0] chanAData,
  output logic [13:0] chanBData,
  output logic [5:0] swingCode,
  output logic perfTuneBit0,
  output logic [1:0] perfTunePair,
  output logic [3:0] chanAGainField,
  output logic [3:0] chanBGainField,
  output logic offsetCorrOn,
  output logic cmosMode,
  output logic [1:0] parallelClockDrive,
  output logic chanADataEn,
  output logic chanBDataEn,
  output logic clockOutEn,
  output logic [3:0] outputClockDelayField
);

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic [1:0] rstPipe_r;
  logic rstSync_b;

  // two-stage release of the asynchronous reset
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rstPipe_r <= 2'h0;
    end else begin
      rstPipe_r <= {rstPipe_r[0], 1'b1};
    end
  end

  assign rstSync_b = rstPipe_r[1];

  // ----------------------------------------------------------------
  // serial port
  // ----------------------------------------------------------------
  logic [7:0] cycleAddr;
  logic [7:0] cycleData;
  logic writeStrobe;
  logic [7:0] readData;

  serial_cfg_port u_port (
    .ref_clk(ref_clk),
    .rstSync_b(rstSync_b),
    .serialEnable_b(serialEnable_b),
    .serialClock(serialClock),
    .serialDataIn(serialDataIn),
    .readData(readData),
    .cycleAddr(cycleAddr),
    .cycleData(cycleData),
    .writeStrobe(writeStrobe),
    .serialDataOutPin(serialDataOutPin)
  );

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  logic readout_r, readout_nxt;
  logic [7:0] swing_r, swing_nxt;
  logic [7:0] tune0_r, tune0_nxt;
  logic [7:0] tune1_r, tune1_nxt;
  logic [7:0] gainA_r, gainA_nxt;
  logic [7:0] format_r, format_nxt;
  logic [7:0] gainB_r, gainB_nxt;
  logic [7:0] offs_r, offs_nxt;
  logic [7:0] custHi_r, custHi_nxt;
  logic [7:0] custLo_r, custLo_nxt;
  logic [7:0] iface_r, iface_nxt;
  logic [7:0] clkDly_r, clkDly_nxt;
  logic [7:0] digEn_r, digEn_nxt;
  logic writeOk;

  // control register stays writable so readback can be switched off
  assign writeOk = writeStrobe && (!readout_r || cycleAddr == ADDR_CTRL);

  // write decode; soft reset returns everything to its default
  always_comb begin
    readout_nxt = readout_r;
    swing_nxt = swing_r;
    tune0_nxt = tune0_r;
    tune1_nxt = tune1_r;
    gainA_nxt = gainA_r;
    format_nxt = format_r;
    gainB_nxt = gainB_r;
    offs_nxt = offs_r;
    custHi_nxt = custHi_r;
    custLo_nxt = custLo_r;
    iface_nxt = iface_r;
    clkDly_nxt = clkDly_r;
    digEn_nxt = digEn_r;
    if (writeOk) begin
      if (cycleAddr == ADDR_CTRL) begin
        if (cycleData[CTRL_RESET_BIT]) begin
          readout_nxt = 1'b0;
          swing_nxt = REG_RESET;
          tune0_nxt = REG_RESET;
          tune1_nxt = REG_RESET;
          gainA_nxt = REG_RESET;
          format_nxt = REG_RESET;
          gainB_nxt = REG_RESET;
          offs_nxt = REG_RESET;
          custHi_nxt = REG_RESET;
          custLo_nxt = REG_RESET;
          iface_nxt = REG_RESET;
          clkDly_nxt = REG_RESET;
          digEn_nxt = REG_RESET;
        end else begin
          readout_nxt = cycleData[CTRL_READOUT_BIT];
        end
      end else if (cycleAddr == ADDR_SWING) begin
        swing_nxt = cycleData & MASK_SWING;
      end else if (cycleAddr == ADDR_TUNE0) begin
        tune0_nxt = cycleData & MASK_TUNE0;
      end else if (cycleAddr == ADDR_TUNE1) begin
        tune1_nxt = cycleData & MASK_TUNE1;
      end else if (cycleAddr == ADDR_GAIN_A) begin
        gainA_nxt = cycleData & MASK_GAIN;
      end else if (cycleAddr == ADDR_FORMAT) begin
        format_nxt = cycleData & MASK_FORMAT;
      end else if (cycleAddr == ADDR_GAIN_B) begin
        gainB_nxt = cycleData & MASK_GAIN;
      end else if (cycleAddr == ADDR_OFFS) begin
        offs_nxt = cycleData & MASK_OFFS;
      end else if (cycleAddr == ADDR_CUST_HI) begin
        custHi_nxt = cycleData & MASK_CUST_HI;
      end else if (cycleAddr == ADDR_CUST_LO) begin
        custLo_nxt = cycleData & MASK_CUST_LO;
      end else if (cycleAddr == ADDR_IFACE) begin
        iface_nxt = cycleData & MASK_IFACE;
      end else if (cycleAddr == ADDR_CLKDLY) begin
        clkDly_nxt = cycleData & MASK_CLKDLY;
      end else if (cycleAddr == ADDR_DIGEN) begin
        digEn_nxt = cycleData & MASK_DIGEN;
      end
    end
  end

  // register storage, all zero from reset
  always_ff @(posedge ref_clk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      readout_r <= 1'b0;
      swing_r <= REG_RESET;
      tune0_r <= REG_RESET;
      tune1_r <= REG_RESET;
      gainA_r <= REG_RESET;
      format_r <= REG_RESET;
      gainB_r <= REG_RESET;
      offs_r <= REG_RESET;
      custHi_r <= REG_RESET;
      custLo_r <= REG_RESET;
      iface_r <= REG_RESET;
      clkDly_r <= REG_RESET;
      digEn_r <= REG_RESET;
    end else begin
      readout_r <= readout_nxt;
      swing_r <= swing_nxt;
      tune0_r <= tune0_nxt;
      tune1_r <= tune1_nxt;
      gainA_r <= gainA_nxt;
      format_r <= format_nxt;
      gainB_r <= gainB_nxt;
      offs_r <= offs_nxt;
      custHi_r <= custHi_nxt;
      custLo_r <= custLo_nxt;
      iface_r <= iface_nxt;
      clkDly_r <= clkDly_nxt;
      digEn_r <= digEn_nxt;
    end
  end

  // ----------------------------------------------------------------
  // readback mux
  // ----------------------------------------------------------------
  // control register and unmapped addresses read as zero
  always_comb begin
    readData = 8'h00;
    if (cycleAddr == ADDR_SWING) begin
      readData = swing_r;
    end else if (cycleAddr == ADDR_TUNE0) begin
      readData = tune0_r;
    end else if (cycleAddr == ADDR_TUNE1) begin
      readData = tune1_r;
    end else if (cycleAddr == ADDR_GAIN_A) begin
      readData = gainA_r;
    end else if (cycleAddr == ADDR_FORMAT) begin
      readData = format_r;
    end else if (cycleAddr == ADDR_GAIN_B) begin
      readData = gainB_r;
    end else if (cycleAddr == ADDR_OFFS) begin
      readData = offs_r;
    end else if (cycleAddr == ADDR_CUST_HI) begin
      readData = custHi_r;
    end else if (cycleAddr == ADDR_CUST_LO) begin
      readData = custLo_r;
    end else if (cycleAddr == ADDR_IFACE) begin
      readData = iface_r;
    end else if (cycleAddr == ADDR_CLKDLY) begin
      readData = clkDly_r;
    end else if (cycleAddr == ADDR_DIGEN) begin
      readData = digEn_r;
    end
  end

  // ----------------------------------------------------------------
  // pin and buffer enables
  // ----------------------------------------------------------------
  logic sdoEn_r, sdoEn_nxt;
  logic enA_r, enA_nxt;
  logic enB_r, enB_nxt;
  logic enClk_r, enClk_nxt;
  logic cmos_r, cmos_nxt;
  logic [1:0] bufPd;

  assign bufPd = iface_r[BUFPD_LSB +: 2];

  // enables derived from the stored fields
  always_comb begin
    sdoEn_nxt = readout_r;
    enA_nxt = ~bufPd[1];
    enB_nxt = ~bufPd[0];
    enClk_nxt = bufPd != BUFPD_BOTH;
    cmos_nxt = iface_r[IFACE_LSB +: 2] == IFACE_CMOS;
  end

  always_ff @(posedge ref_clk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      sdoEn_r <= 1'b0;
      enA_r <= 1'b1;
      enB_r <= 1'b1;
      enClk_r <= 1'b1;
      cmos_r <= 1'b0;
    end else begin
      sdoEn_r <= sdoEn_nxt;
      enA_r <= enA_nxt;
      enB_r <= enB_nxt;
      enClk_r <= enClk_nxt;
      cmos_r <= cmos_nxt;
    end
  end

  // ----------------------------------------------------------------
  // per-channel data path
  // ----------------------------------------------------------------
  logic [2:0] patSel [2];
  logic [13:0] chanIn [2];
  logic [13:0] chanOut [2];
  logic [13:0] customPattern;
  logic offsetBinary;

  assign customPattern = {custHi_r[5:0], custLo_r};
  assign offsetBinary = format_r[FORMAT_LSB +: 2] == FORMAT_OFFSET_BIN;
  assign patSel[0] = gainA_r[PAT_LSB +: 3];
  assign patSel[1] = gainB_r[PAT_LSB +: 3];
  assign chanIn[0] = chanASample;
  assign chanIn[1] = chanBSample;

  // one pattern source per channel
  for (genvar ch = 0; ch < 2; ch++) begin : g_chan
    test_pattern_gen u_pat (
      .ref_clk(ref_clk),
      .rstSync_b(rstSync_b),
      .patternSel(patSel[ch]),
      .customPattern(customPattern),
      .digitalEn(digEn_r[DIGEN_BIT]),
      .offsetBinary(offsetBinary),
      .sampleIn(chanIn[ch]),
      .sampleOut(chanOut[ch])
    );
  end

  // ----------------------------------------------------------------
  // outputs, each a register or a register field
  // ----------------------------------------------------------------
  assign serialDataOutEn = sdoEn_r;
  assign chanAData = chanOut[0];
  assign chanBData = chanOut[1];
  assign swingCode = swing_r[SWING_LSB +: 6];
  assign perfTuneBit0 = tune0_r[TUNE0_BIT];
  assign perfTunePair = tune1_r[TUNE1_LSB +: 2];
  assign chanAGainField = gainA_r[GAIN_LSB +: 4];
  assign chanBGainField = gainB_r[GAIN_LSB +: 4];
  assign offsetCorrOn = offs_r[OFFS_BIT];
  assign cmosMode = cmos_r;
  assign parallelClockDrive = iface_r[DRIVE_LSB +: 2];
  assign chanADataEn = enA_r;
  assign chanBDataEn = enB_r;
  assign clockOutEn = enClk_r;
  assign outputClockDelayField = clkDly_r[CLKDLY_LSB +: 4];

endmodule

// File: verification/adc_cfg_checker.sv
// port assertions for the converter configuration register bank
`timescale 1ns/1ps
module adc_cfg_checker (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic serialEnable_b,
  input wire logic serialDataOutPin,
  input wire logic serialDataOutEn,
  input wire logic [5:0] swingCode,
  input wire logic [3:0] chanAGainField,
  input wire logic [3:0] chanBGainField,
  input wire logic cmosMode,
  input wire logic chanADataEn,
  input wire logic chanBDataEn,
  input wire logic clockOutEn
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  // ----------------------------------------------------------------
  // fields move only as the result of a serial frame
  // ----------------------------------------------------------------
  swing_after_frame_a: assert property ($changed(swingCode) |-> !$past(serialEnable_b, 2))
    else $error("swing field changed outside a frame");
  gain_a_frame_a: assert property ($changed(chanAGainField) |-> !$past(serialEnable_b, 2))
    else $error("channel A gain changed outside a frame");
  iface_after_frame_a: assert property ($changed(cmosMode) |-> !$past(serialEnable_b, 3))
    else $error("interface mode changed outside a frame");
  // ----------------------------------------------------------------
  // readback pin and write lockout
  // ----------------------------------------------------------------
  readout_on_frame_a: assert property ($rose(serialDataOutEn) |-> !$past(serialEnable_b, 3))
    else $error("readback enable rose without a write");
  readout_shift_a: assert property (serialDataOutEn && $changed(serialDataOutPin) |-> !$past(serialEnable_b, 2))
    else $error("readback pin moved outside a frame");
  write_lockout_a: assert property (serialDataOutEn && $past(serialDataOutEn) |=> $stable(chanBGainField))
    else $error("gain written while readback enabled");
  // ----------------------------------------------------------------
  // buffer power-down coding
  // ----------------------------------------------------------------
  clock_buf_on_a: assert property (clockOutEn |-> chanADataEn || chanBDataEn)
    else $error("clock buffer on with both data buffers off");
  clock_buf_off_a: assert property (!clockOutEn |-> !chanADataEn && !chanBDataEn)
    else $error("clock buffer off with a data buffer on");
endmodule
bind adc_serial_config_registers adc_cfg_checker adc_cfg_checker_inst (.ref_clk(ref_clk), .rst_b(rst_b),
  .serialEnable_b(serialEnable_b), .serialDataOutPin(serialDataOutPin), .serialDataOutEn(serialDataOutEn),
  .swingCode(swingCode), .chanAGainField(chanAGainField), .chanBGainField(chanBGainField),
  .cmosMode(cmosMode), .chanADataEn(chanADataEn), .chanBDataEn(chanBDataEn), .clockOutEn(clockOutEn));

// File: verification/serial_ctrl_model.sv
// external controller model driving serial configuration frames
`timescale 1ns/1ps
module serial_ctrl_model (
  input wire logic ref_clk,
  input wire logic sdoLine,
  output logic serialEnable_b,
  output logic serialClock,
  output logic serialDataIn
);
  logic heldBit;
  initial begin
    serialEnable_b = 1'b1;
    serialClock = 1'b0;
    serialDataIn = 1'b0;
  end
  // capture readback on the low phase so the edge never races the shifter
  always @(negedge ref_clk) heldBit <= sdoLine;
  // one frame: address then data msb first, readback collected alongside
  task automatic xfer(input logic [7:0] a, input logic [7:0] d, output logic [7:0] rd);
    logic [15:0] v;
    v = {a, d};
    rd = 8'h00;
    @(posedge ref_clk) serialEnable_b <= 1'b0;
    for (int i = 15; i >= 0; i--) begin
      serialDataIn <= v[i];
      @(posedge ref_clk) serialClock <= 1'b1;
      repeat (3) @(posedge ref_clk);
      serialClock <= 1'b0;
      repeat (3) @(posedge ref_clk);
      if (i > 0 && i < 9) rd = {rd[6:0], heldBit};
    end
    serialEnable_b <= 1'b1;
    serialDataIn <= ~serialDataIn;
  endtask
endmodule

// File: verification/adc_serial_config_registers_tb.sv
// self-checking bench for the configuration register bank
`timescale 1ns/1ps
module adc_serial_config_registers_tb;
  import adc_cfg_pkg::*;
  logic ref_clk, rst_b, serialEnable_b, serialClock, serialDataIn, serialDataOutPin, serialDataOutEn, sdoLine;
  logic perfTuneBit0, offsetCorrOn, cmosMode, chanADataEn, chanBDataEn, clockOutEn;
  logic [13:0] chanASample, chanBSample, chanAData, chanBData, p;
  logic [5:0] swingCode;
  logic [3:0] chanAGainField, chanBGainField, outputClockDelayField;
  logic [1:0] perfTunePair, parallelClockDrive;
  logic [7:0] r;
  int errors, checks;
  assign sdoLine = serialDataOutEn ? serialDataOutPin : 1'bz;
  adc_serial_config_registers adc_serial_config_registers_inst (.ref_clk(ref_clk), .rst_b(rst_b),
    .serialEnable_b(serialEnable_b), .serialClock(serialClock), .serialDataIn(serialDataIn),
    .serialDataOutPin(serialDataOutPin), .serialDataOutEn(serialDataOutEn), .chanASample(chanASample),
    .chanBSample(chanBSample), .chanAData(chanAData), .chanBData(chanBData), .swingCode(swingCode),
    .perfTuneBit0(perfTuneBit0), .perfTunePair(perfTunePair), .chanAGainField(chanAGainField),
    .chanBGainField(chanBGainField), .offsetCorrOn(offsetCorrOn), .cmosMode(cmosMode),
    .parallelClockDrive(parallelClockDrive), .chanADataEn(chanADataEn), .chanBDataEn(chanBDataEn),
    .clockOutEn(clockOutEn), .outputClockDelayField(outputClockDelayField));
  serial_ctrl_model serial_ctrl_model_inst (.ref_clk(ref_clk), .sdoLine(sdoLine),
    .serialEnable_b(serialEnable_b), .serialClock(serialClock), .serialDataIn(serialDataIn));
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [13:0] e, input logic [13:0] g);
    checks++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    serial_ctrl_model_inst.xfer(a, d, r);
    repeat (3) @(posedge ref_clk);
    #1;
  endtask
  task automatic print_verdict;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic s_fields;
    logic [5:0] sw [5] = '{6'h1B, 6'h32, 6'h14, 6'h3E, 6'h0F};
    chk("resetSwing", 14'h0, swingCode);
    chk("resetReadout", 14'h0, serialDataOutEn);
    wr(8'hF1, 8'h02);
    foreach (sw[k]) begin
      wr(8'h01, {sw[k], 2'b00});
      chk("swing", sw[k], swingCode);
    end
    wr(8'h25, 8'hC0);
    chk("gainA", 14'hC, chanAGainField);
    wr(8'h2B, 8'hC0);
    chk("gainB", 14'hC, chanBGainField);
    wr(8'h03, 8'h02);
    chk("tune0", 14'h1, perfTuneBit0);
    wr(8'h06, 8'h06);
    chk("tunePair", 14'h3, perfTunePair);
    wr(8'h3D, 8'h20);
    chk("offsCorr", 14'h1, offsetCorrOn);
  endtask
  task automatic s_iface;
    for (int k = 0; k < 4; k++) begin
      wr(8'h41, k[7:0]);
      chk("bufEn", {11'h0, ~k[1], ~k[0], k != 3}, {chanADataEn, chanBDataEn, clockOutEn});
    end
    wr(8'h41, 8'hF0);
    chk("cmos", 14'h1, cmosMode);
    chk("clkDrive", 14'h3, parallelClockDrive);
    wr(8'h42, 8'h70);
    chk("clkDelay", 14'h7, outputClockDelayField);
  endtask
  task automatic s_pattern;
    logic [13:0] ex [3] = '{14'h0000, 14'h3FFF, 14'h15A5};
    logic [2:0] cd [3] = '{3'h1, 3'h2, 3'h5};
    wr(8'h25, 8'h01);
    chk("digOff", 14'h2123, chanAData);
    wr(8'h29, 8'h18);
    chk("offsBin", 14'h0123, chanAData);
    wr(8'h44, 8'h01);
    wr(8'h3F, 8'h15);
    wr(8'h40, 8'hA5);
    foreach (cd[k]) begin
      wr(8'h25, {5'h0, cd[k]});
      chk("patA", ex[k], chanAData);
    end
    wr(8'h25, 8'h03);
    p = chanAData;
    @(posedge ref_clk) #1;
    chk("toggle", p ^ 14'h3FFF, chanAData);
    chk("toggleWord", 14'h1, p == 14'h2AAA || p == 14'h1555);
    wr(8'h25, 8'h04);
    p = chanAData;
    @(posedge ref_clk) #1;
    chk("ramp", p + 14'h1, chanAData);
    wr(8'h25, 8'h06);
    chk("unused", 14'h0123, chanAData);
    wr(8'h2B, 8'h02);
    chk("patB", 14'h3FFF, chanBData);
  endtask
  task automatic s_readback;
    wr(8'h00, 8'h01);
    chk("readOn", 14'h1, serialDataOutEn);
    serial_ctrl_model_inst.xfer(8'h3F, 8'h00, r);
    chk("readHi", 14'h15, r);
    wr(8'h3F, 8'h3F);
    serial_ctrl_model_inst.xfer(8'h3F, 8'h00, r);
    chk("lockout", 14'h15, r);
    wr(8'h2B, 8'hC0);
    chk("lockGainB", 14'h0, chanBGainField);
    serial_ctrl_model_inst.xfer(8'h00, 8'h00, r);
    chk("readCtrl", 14'h0, r);
    wr(8'h00, 8'h00);
    chk("readOff", 14'h0, serialDataOutEn);
  endtask
  task automatic s_softrst;
    wr(8'h2B, 8'hC0);
    chk("preGainB", 14'hC, chanBGainField);
    wr(8'h00, 8'h02);
    chk("rstSwing", 14'h0, swingCode);
    chk("rstGain", 14'h0, chanBGainField);
    wr(8'h01, 8'h0C);
    chk("selfClear", 14'h3, swingCode);
  endtask
  // ----------------------------------------------------------------
  // clock, reset, sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  initial begin
    #400us;
    errors++;
    print_verdict();
  end
  initial begin
    rst_b = 1'b0;
    chanASample = 14'h0;
    chanBSample = 14'h0;
    repeat (2) @(posedge ref_clk);
    rst_b <= 1'b1;
    chanASample <= 14'h0123;
    chanBSample <= 14'h0456;
    repeat (3) @(posedge ref_clk);
    #1;
    s_fields();
    s_iface();
    s_pattern();
    s_readback();
    s_softrst();
    print_verdict();
  end
endmodule
